// ==== rtl/maskable_interrupt_control.sv ====
// Maskable interrupt control: flags, mask, edge select, status word, acceptance
// Contract
// (R1) Mask bit 0 enables, 1 disables servicing
// (R2) Mask register resets to FFH
// (R3) Mask accepts bit and byte writes
// (R4) Output-mode level change on pin sets flag
// (R5) Edge fields: 00 fall, 01 rise, 11 both
// (R6) Software writes zero to edge bits 0,1,6,7
// (R7) Edge select written by whole byte only
// (R8) Edge select resets to 00H
// (R9) Software masks, sets edge, clears flag, unmasks
// (R10) Enable flag: byte, bit, instructions; acceptance clears
// (R11) Status word resets to 02H
// (R12) Accept needs flag 1, mask 0, enable 1
// (R13) Servicing starts 9 to 19 clocks after request
// (R14) Simultaneous requests taken highest priority first
// (R15) Unaccepted requests stay pending until allowed
// (R16) Push status, push PC, clear enable, vector
// (R17) Flag before clock n-1: accept after instruction
// (R18) Flag in last clock: accept after next instruction
// (R19) Flag or mask access defers acceptance one instruction
// (R20) Re-enabled handler nests any unmasked request
// (R21) Handler with enable clear leaves requests pending
// (R22) Software masks lower sources for priority nesting
// (R23) Priority: voltage, pin0, pin1, timer8, timer16 a/b, conversion
// (R24) Flag set by source or software, cleared on accept
// (R25) Return pops PC then status, restoring enable
`timescale 1ns/1ps
module maskable_interrupt_control (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Special function register access from the CPU
    input  wire irq_ctrl_pkg::sfr_req_t sfr_req,
    output logic [7:0]                  sfr_rdata,
    // Status word commands from the CPU
    input  wire irq_ctrl_pkg::psw_cmd_t psw_cmd,
    output logic [7:0]                  cpu_status_word,
    // Instruction sequencing from the CPU
    input  wire logic                   instr_end,
    input  wire logic [15:0]            pc_value,
    // Acceptance sequence toward the CPU
    output logic                        cpu_hold,
    output logic                        stack_push,
    output logic [7:0]                  stack_data,
    output logic                        pc_load,
    output logic [15:0]                 pc_load_value,
    // Request sources
    input  wire irq_ctrl_pkg::irq_src_t int_src,
    input  wire logic                   ext_pin_irq0,
    input  wire logic                   ext_pin_irq1,
    input  wire logic [1:0]             pin_out_mode,
    input  wire logic [1:0]             pin_out_level,
    // Register contents for observation
    output logic [7:0]                  request_flag_bits,
    output logic [7:0]                  source_mask_bits,
    output logic [7:0]                  pin_edge_select
);
    import irq_ctrl_pkg::*;

    // ==========================================================
    // Write decoding shared by the bit-writable registers
    function automatic logic [7:0] sfr_apply(input logic [7:0] old, input sfr_req_t req);
        logic [7:0] res;
        res = old;
        if (req.bit_op) begin
            res[req.bit_sel] = req.wdata[0];
        end else begin
            res = req.wdata;
        end
        return res;
    endfunction

    // ==========================================================
    // Registers
    logic [7:0]  flag_q;
    logic [7:0]  flag_d;
    logic [7:0]  mask_q;
    logic [7:0]  mask_d;
    logic [7:0]  edge_q;
    logic [7:0]  edge_d;
    logic [7:0]  psw_q;
    logic [7:0]  psw_d;
    logic [7:0]  rdata_q;
    logic        touch_q;
    logic [2:0]  sel_q;
    ack_state_t  state_q;
    ack_state_t  state_d;
    logic        hold_q;
    logic        push_q;
    logic [7:0]  push_data_q;
    logic        load_q;
    logic [15:0] load_value_q;

    // ==========================================================
    // Address decode
    logic hit_flags;
    logic hit_mask;
    logic hit_edge;
    logic wr_flags;
    logic wr_mask;
    logic wr_edge;
    logic touch_now;
    logic defer;

    assign hit_flags = (sfr_req.addr == ADDR_REQUEST_FLAGS);
    assign hit_mask  = (sfr_req.addr == ADDR_SOURCE_MASK);
    assign hit_edge  = (sfr_req.addr == ADDR_EDGE_SELECT);
    assign wr_flags  = sfr_req.wr & hit_flags;
    assign wr_mask   = sfr_req.wr & hit_mask;                                          // R3
    assign wr_edge   = sfr_req.wr & hit_edge & ~sfr_req.bit_op;                        // R7
    // Any touch of the flag or mask register blocks acceptance at this boundary
    assign touch_now = (sfr_req.rd | sfr_req.wr) & (hit_flags | hit_mask);             // R19
    assign defer     = touch_q | touch_now;                                            // R19

    // ==========================================================
    // Pin edge detection
    logic [1:0] pin_raw;
    logic [1:0] pin_edge;
    edge_sel_t  pin_sel [2];

    assign pin_raw    = {ext_pin_irq1, ext_pin_irq0};
    assign pin_sel[0] = edge_sel_t'(edge_q[PIN0_EDGE_LO_POS +: 2]);                    // R5
    assign pin_sel[1] = edge_sel_t'(edge_q[PIN1_EDGE_LO_POS +: 2]);                    // R5

    generate
        for (genvar p = 0; p < 2; p++) begin : g_pin
            pin_edge_detect u_edge (
                .clk       (clk),
                .reset     (reset),
                .pin_raw   (pin_raw[p]),
                .out_mode  (pin_out_mode[p]),
                .out_level (pin_out_level[p]),                                         // R4
                .edge_sel  (pin_sel[p]),
                .edge_pulse(pin_edge[p])
            );
        end
    endgenerate

    // ==========================================================
    // Hardware request sets, laid out in priority order
    logic [7:0] hw_set;

    assign hw_set = {1'b0,
                     int_src.conversion_done_irq,
                     int_src.timer16_event_b_irq,
                     int_src.timer16_event_a_irq,
                     int_src.timer8_match_irq,
                     pin_edge[1],
                     pin_edge[0],
                     int_src.low_voltage_irq};                                         // R23

    // ==========================================================
    // Eligibility and priority pick
    logic [6:0] eligible;
    logic       pick_any;
    logic [2:0] pick_idx;
    logic       ie;
    logic       take;
    logic [7:0] take_clr;

    assign eligible = flag_q[6:0] & ~mask_q[6:0];                                      // R1 R12
    assign ie       = psw_q[PSW_IE_BIT];

    irq_pick u_pick (
        .eligible(eligible),
        .any     (pick_any),
        .idx     (pick_idx)                                                            // R14
    );

    // Flags are sampled registered, so a set in an instruction's last clock
    // is first seen at the following boundary
    assign take     = instr_end & (state_q == ACK_IDLE) & ~defer              // R12 R13
                    & ie & pick_any;                                         // R17 R18
    assign take_clr = take ? (8'h01 << pick_idx) : 8'h00;

    // ==========================================================
    // Next register values
    logic [7:0] flag_sw;

    assign flag_sw = wr_flags ? sfr_apply(flag_q, sfr_req) : flag_q;
    // Hardware set wins over both software clear and acceptance clear
    assign flag_d  = (flag_sw & ~take_clr) | hw_set;                                   // R24 R15
    assign mask_d  = wr_mask ? sfr_apply(mask_q, sfr_req) : mask_q;                    // R3
    // Bits outside the two fields are held at zero whatever is written
    assign edge_d  = wr_edge ? (sfr_req.wdata & EDGE_WRITABLE_BITS) : edge_q;          // R6 R7

    always_comb begin
        psw_d = psw_q;
        if (take) begin
            psw_d[PSW_IE_BIT] = 1'b0;                                                  // R10 R16
        end else if (psw_cmd.return_from_irq_instruction_pop) begin
            psw_d = psw_cmd.return_from_irq_instruction_data;                                                 // R25
        end else if (psw_cmd.byte_wr) begin
            psw_d = psw_cmd.wdata;                                                     // R10
        end else if (psw_cmd.bit_wr) begin
            psw_d[psw_cmd.bit_sel] = psw_cmd.wdata[0];                                 // R10
        end else if (psw_cmd.ei) begin
            psw_d[PSW_IE_BIT] = 1'b1;                                                  // R10 R20
        end else if (psw_cmd.di) begin
            psw_d[PSW_IE_BIT] = 1'b0;                                                  // R10 R21
        end
    end

    // ==========================================================
    // Acceptance sequence
    logic [15:0] vector_addr;
    logic [7:0]  push_data_d;
    logic        push_d;

    assign vector_addr = VEC_BASE + (VEC_STEP * {13'h0000, sel_q});

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ACK_IDLE:  state_d = take ? ACK_PSW : ACK_IDLE;
            ACK_PSW:   state_d = ACK_PC_HI;
            ACK_PC_HI: state_d = ACK_PC_LO;
            ACK_PC_LO: state_d = ACK_VEC;
            ACK_VEC:   state_d = ACK_IDLE;
            default:   state_d = ACK_IDLE;
        endcase
    end

    // Status word goes first, captured before the enable clears
    assign push_d      = (state_d == ACK_PSW) | (state_d == ACK_PC_HI)
                       | (state_d == ACK_PC_LO);                                       // R16
    assign push_data_d = (state_d == ACK_PSW)   ? psw_q :
                         (state_d == ACK_PC_HI) ? pc_value[15:8] : pc_value[7:0];      // R16

    // ==========================================================
    // Register read
    logic [7:0] rd_mux;

    assign rd_mux = hit_flags ? flag_q :
                    hit_mask  ? mask_q :
                    hit_edge  ? edge_q : 8'h00;

    // ==========================================================
    // Flip-flops
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q  <= RST_REQUEST_FLAGS;                                              // R24
            mask_q  <= RST_SOURCE_MASK;                                                // R2
            edge_q  <= RST_EDGE_SELECT;                                                // R8
            psw_q   <= RST_STATUS_WORD;                                                // R11
            rdata_q <= 8'h00;
            touch_q <= 1'b0;
        end else begin
            flag_q  <= flag_d;
            mask_q  <= mask_d;
            edge_q  <= edge_d;
            psw_q   <= psw_d;
            rdata_q <= sfr_req.rd ? rd_mux : rdata_q;
            touch_q <= instr_end ? 1'b0 : (touch_q | touch_now);                       // R19
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q      <= ACK_IDLE;
            sel_q        <= 3'h0;
            hold_q       <= 1'b0;
            push_q       <= 1'b0;
            push_data_q  <= 8'h00;
            load_q       <= 1'b0;
            load_value_q <= 16'h0000;
        end else begin
            state_q      <= state_d;
            sel_q        <= take ? pick_idx : sel_q;
            hold_q       <= (state_d != ACK_IDLE);
            push_q       <= push_d;
            push_data_q  <= push_d ? push_data_d : push_data_q;
            load_q       <= (state_d == ACK_VEC);                                      // R16
            load_value_q <= (state_d == ACK_VEC) ? vector_addr : load_value_q;         // R16
        end
    end

    assign sfr_rdata         = rdata_q;
    assign cpu_status_word   = psw_q;
    assign cpu_hold          = hold_q;
    assign stack_push        = push_q;
    assign stack_data        = push_data_q;
    assign pc_load           = load_q;
    assign pc_load_value     = load_value_q;
    assign request_flag_bits = flag_q;
    assign source_mask_bits  = mask_q;
    assign pin_edge_select   = edge_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Reset checks must run while reset is high, so they set the default disable aside
    a_mask_reset_value: assert property (disable iff (1'b0) // R2
        reset |=> mask_q == RST_SOURCE_MASK)
        else $error("mask register not FFH in reset");
    a_edge_psw_reset: assert property (disable iff (1'b0) // R8 R11
        reset |=> edge_q == RST_EDGE_SELECT && psw_q == RST_STATUS_WORD)
        else $error("edge select or status word not reset");
    a_take_needs_cond: assert property (take |-> flag_q[pick_idx] && !mask_q[pick_idx] // R1 R12
        && psw_q[PSW_IE_BIT])
        else $error("acceptance without flag, mask or enable");
    a_take_priority: assert property (take |-> // R14
        (eligible & ((7'h01 << pick_idx) - 7'h01)) == 7'h00)
        else $error("higher priority request passed over");
    a_defer_blocks: assert property (instr_end && defer |-> !take) // R19
        else $error("acceptance during flag or mask access");
    a_ie_cleared: assert property (take |=> !psw_q[7] && stack_data == $past(psw_q)) // R10
        else $error("enable not cleared or wrong status pushed");
    a_push_order: assert property (take |=> // R16
        stack_push ##1 stack_push ##1 stack_push ##1 pc_load)
        else $error("acceptance sequence out of order");
    a_hold_window: assert property (take |=> cpu_hold [*4] ##1 !cpu_hold) // R16
        else $error("core hold not four cycles");
    a_vector_value: assert property (take |-> ##4 // R16
        pc_load_value == 16'h0006 + 16'h0002 * $past(pick_idx, 4))
        else $error("wrong vector address");
    a_accept_clears: assert property (take && !hw_set[pick_idx] |=> // R24
        !flag_q[$past(pick_idx)])
        else $error("accepted request flag not cleared");
    a_hw_set_wins: assert property (hw_set != 8'h00 |=> // R24 R15
        (flag_q & $past(hw_set)) == $past(hw_set))
        else $error("hardware request not latched");
    a_pin_flag_set: assert property (pin_edge[1] |=> flag_q[SRC_PIN1]) // R4
        else $error("pin edge did not set its flag");
    a_mask_bit_write: assert property (wr_mask && sfr_req.bit_op |=> // R3
        mask_q[$past(sfr_req.bit_sel)] == $past(sfr_req.wdata[0]))
        else $error("mask bit write not applied");
    a_enable_cmd_sets: assert property (psw_cmd.ei && !take && !psw_cmd.return_from_irq_instruction_pop // R10 R20
        && !psw_cmd.byte_wr && !psw_cmd.bit_wr |=> psw_q[PSW_IE_BIT])
        else $error("enable instruction did not set enable");
    a_edge_byte_only: assert property (sfr_req.wr && sfr_req.bit_op && hit_edge |=> // R7
        $stable(edge_q))
        else $error("edge select changed by bit write");
    a_edge_zero_bits: assert property ((edge_q & 8'hc3) == 8'h00) // R6
        else $error("edge select reserved bit set");
    a_pending_held: assert property (eligible[0] && !take && !wr_flags |=> flag_q[0]) // R15
        else $error("pending request lost");
    a_return_from_irq_instruction_restore: assert property (psw_cmd.return_from_irq_instruction_pop && !take |=> // R25
        psw_q == $past(psw_cmd.return_from_irq_instruction_data))
        else $error("return did not restore status word");

    c_accept: cover property (take ##4 pc_load);
    c_nested: cover property (take ##5 psw_cmd.ei ##[1:40] take);
    c_deferred: cover property (instr_end && defer && ie && pick_any);
    c_pin_edge: cover property (pin_edge[1] && pin_out_mode[1]);
    c_return_accept: cover property (psw_cmd.return_from_irq_instruction_pop ##[1:20] take);
endmodule

// ==== rtl/irq_ctrl_pkg.sv ====
// Constants, codes and carrier types for the maskable interrupt control block
package irq_ctrl_pkg;

    // ==========================================================
    // Register addresses and reset values
    localparam logic [15:0] ADDR_REQUEST_FLAGS = 16'hffe0;
    localparam logic [15:0] ADDR_SOURCE_MASK   = 16'hffe4;
    localparam logic [15:0] ADDR_EDGE_SELECT   = 16'hffec;
    localparam logic [7:0]  RST_REQUEST_FLAGS  = 8'h00;
    localparam logic [7:0]  RST_SOURCE_MASK    = 8'hff;
    localparam logic [7:0]  RST_EDGE_SELECT    = 8'h00;
    localparam logic [7:0]  RST_STATUS_WORD    = 8'h02;

    // ==========================================================
    // Field positions
    localparam logic [2:0]  PSW_IE_BIT         = 3'h7;
    localparam int          PIN1_EDGE_LO_POS   = 4;
    localparam int          PIN0_EDGE_LO_POS   = 2;
    localparam logic [7:0]  EDGE_WRITABLE_BITS = 8'h3c;

    // ==========================================================
    // Sources, in priority order: index 0 is the highest
    localparam int          NUM_SRC            = 7;
    localparam int          SRC_LOW_VOLTAGE    = 0;
    localparam int          SRC_PIN0           = 1;
    localparam int          SRC_PIN1           = 2;
    localparam int          SRC_TIMER8         = 3;
    localparam int          SRC_TIMER16_A      = 4;
    localparam int          SRC_TIMER16_B      = 5;
    localparam int          SRC_CONVERSION     = 6;
    localparam logic [15:0] VEC_BASE           = 16'h0006;
    localparam logic [15:0] VEC_STEP           = 16'h0002;

    // ==========================================================
    // Service latency, in CPU clocks, from request to vectored servicing
    localparam int          LAT_MIN_CLK        = 9;
    localparam int          LAT_MAX_CLK        = 19;

    // ==========================================================
    // Codes
    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_BAD  = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_t;

    typedef enum logic [2:0] {
        ACK_IDLE  = 3'b000,
        ACK_PSW   = 3'b001,
        ACK_PC_HI = 3'b010,
        ACK_PC_LO = 3'b011,
        ACK_VEC   = 3'b100
    } ack_state_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        bit_op;
        logic [15:0] addr;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
    } sfr_req_t;

    typedef struct packed {
        logic        byte_wr;
        logic        bit_wr;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
        logic        ei;
        logic        di;
        logic        return_from_irq_instruction_pop;
        logic [7:0]  return_from_irq_instruction_data;
    } psw_cmd_t;

    typedef struct packed {
        logic conversion_done_irq;
        logic timer16_event_b_irq;
        logic timer16_event_a_irq;
        logic timer8_match_irq;
        logic low_voltage_irq;
    } irq_src_t;

endpackage

// ==== rtl/pin_edge_detect.sv ====
// Edge detector for one external interrupt pin, with port output mode loopback
`timescale 1ns/1ps
module pin_edge_detect (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Pin and port state
    input  wire logic                    pin_raw,
    input  wire logic                    out_mode,
    input  wire logic                    out_level,
    // Edge selection and result
    input  wire irq_ctrl_pkg::edge_sel_t edge_sel,
    output logic                         edge_pulse
);
    import irq_ctrl_pkg::*;

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic primed_q;
    logic level;
    logic rise;
    logic fall;

    // In output mode the driven level is seen as the pin level
    assign level = out_mode ? out_level : sync2_q;
    assign rise  = level & ~prev_q;
    assign fall  = ~level & prev_q;
    // The prohibited code detects nothing
    assign edge_pulse = primed_q & (((edge_sel == EDGE_RISE) & rise)
                                  | ((edge_sel == EDGE_FALL) & fall)
                                  | ((edge_sel == EDGE_BOTH) & (rise | fall)));

    always_ff @(posedge clk) begin
        sync1_q <= pin_raw;
        sync2_q <= sync1_q;
        if (reset) begin
            prev_q   <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= level;
            primed_q <= 1'b1;
        end
    end
endmodule

// ==== rtl/irq_pick.sv ====
// Fixed priority picker: the lowest index among the eligible sources wins
`timescale 1ns/1ps
module irq_pick (
    // Requests
    input  wire logic [6:0] eligible,
    // Winner
    output logic            any,
    output logic [2:0]      idx
);
    import irq_ctrl_pkg::*;

    always_comb begin
        any = 1'b0;
        idx = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                any = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule

// ==== test/core_model.sv ====
// Behavioural model of the CPU core that faces the interrupt control block
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Acceptance sequence from the block
    input  wire logic        cpu_hold,
    input  wire logic        stack_push,
    input  wire logic [7:0]  stack_data,
    input  wire logic        pc_load,
    // Instruction sequencing to the block
    output logic             instr_end,
    output logic [15:0]      pc_value,
    // Observation for the bench
    output logic [23:0]      pushed,
    output logic [7:0]       n_acc
);
    logic [1:0] phase_q;

    // ==========================================================
    // Four-clock instructions; the core stalls while held
    assign instr_end = (phase_q == 2'h3) && !cpu_hold;
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= 2'h0;
            pc_value <= 16'h1234;
            pushed <= 24'h0;
            n_acc <= 8'h0;
        end else begin
            // A vector load starts a fresh instruction, so the next boundary is four clocks on
            phase_q <= pc_load ? 2'h0 : (cpu_hold ? phase_q : phase_q + 2'h1);
            if (instr_end)
                pc_value <= pc_value + 16'h0002;
            // Stack bytes arrive status word first, then the program counter
            if (stack_push)
                pushed <= {pushed[15:0], stack_data};
            if (pc_load)
                n_acc <= n_acc + 8'h1;
        end
    end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the maskable interrupt control block
`timescale 1ns/1ps
module testbench;
    import irq_ctrl_pkg::*;
    logic        clk, reset, instr_end, cpu_hold, stack_push, pc_load;
    logic        ext_pin_irq0, ext_pin_irq1;
    logic [15:0] pc_value, pc_load_value;
    logic [7:0]  sfr_rdata, cpu_status_word, stack_data, n_acc;
    logic [7:0]  request_flag_bits, source_mask_bits, pin_edge_select;
    logic [1:0]  pin_out_mode, pin_out_level;
    logic [23:0] pushed;
    sfr_req_t    sfr_req;
    psw_cmd_t    psw_cmd;
    irq_src_t    int_src;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;

    maskable_interrupt_control maskable_interrupt_control_inst (
        .clk, .reset, .sfr_req, .sfr_rdata, .psw_cmd, .cpu_status_word,
        .instr_end, .pc_value, .cpu_hold, .stack_push, .stack_data, .pc_load,
        .pc_load_value, .int_src, .ext_pin_irq0, .ext_pin_irq1, .pin_out_mode,
        .pin_out_level, .request_flag_bits, .source_mask_bits, .pin_edge_select);
    core_model core_model_inst (
        .clk, .reset, .cpu_hold, .stack_push, .stack_data, .pc_load,
        .instr_end, .pc_value, .pushed, .n_acc);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One register access; read data is settled one edge after the take
    task automatic acc(input logic w, input logic b, input logic [15:0] a,
                       input logic [2:0] s, input logic [7:0] d);
        @(negedge clk);
        sfr_req = '{rd: !w, wr: w, bit_op: b, addr: a, bit_sel: s, wdata: d};
        @(negedge clk);
        sfr_req = '0;
        @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic e, input logic dd, input logic bw, input logic rp);
        @(negedge clk);
        psw_cmd = '{byte_wr: 1'b0, bit_wr: bw, bit_sel: 3'h7, wdata: 8'h01, ei: e,
                    di: dd, return_from_irq_instruction_pop: rp, return_from_irq_instruction_data: 8'h82};
        @(negedge clk);
        psw_cmd = '0;
    endtask

    // Waits for the vector load, bounded, then checks vector, stack and enable
    task automatic wait_acc(input logic [15:0] vec);
        int k;
        k = 0;
        while (pc_load !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk({pc_load, cpu_hold}, 2'h3);
        chk(pc_load_value, vec);
        chk(pushed, {8'h82, pc_value});
        chk(cpu_status_word, 8'h02);
    endtask

    task automatic results();
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        sfr_req = '0;
        psw_cmd = '0;
        int_src = '0;
        ext_pin_irq0 = 1'b0;
        ext_pin_irq1 = 1'b0;
        pin_out_mode = 2'h0;
        pin_out_level = 2'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        acc(0, 0, 16'hffe4, 3'h0, 8'h00); chk(sfr_rdata, 8'hff);
        acc(0, 0, 16'hffec, 3'h0, 8'h00); chk(sfr_rdata, 8'h00);
        acc(0, 0, 16'hffe0, 3'h0, 8'h00); chk(sfr_rdata, 8'h00);
        chk(cpu_status_word, 8'h02);
        acc(1, 0, 16'hffec, 3'h0, 8'h3c); chk(pin_edge_select, 8'h3c);
        acc(1, 1, 16'hffec, 3'h2, 8'h00); chk(pin_edge_select, 8'h3c);
        // Pin 0 rising, pin 1 falling; mask is still set, then flags cleared
        acc(1, 0, 16'hffec, 3'h0, 8'h04);
        acc(1, 0, 16'hffe0, 3'h0, 8'h00);
        cmd(1, 0, 0, 0); chk(cpu_status_word, 8'h82);
        cmd(0, 1, 0, 0); chk(cpu_status_word, 8'h02);
        cmd(1, 0, 0, 0); chk(cpu_status_word, 8'h82);
        @(negedge clk);
        ext_pin_irq0 = 1'b1;
        repeat (10) @(negedge clk);
        acc(0, 0, 16'hffe0, 3'h0, 8'h00); chk(sfr_rdata, 8'h02);
        chk(n_acc, 8'h0);
        @(negedge clk);
        // Two sources at once; the higher one must win
        int_src = '{conversion_done_irq: 1'b0, timer16_event_b_irq: 1'b0,
                    timer16_event_a_irq: 1'b0, timer8_match_irq: 1'b1, low_voltage_irq: 1'b1};
        @(negedge clk);
        int_src = '0;
        acc(1, 0, 16'hffe4, 3'h0, 8'hf6);
        wait_acc(16'h0006);
        acc(1, 1, 16'hffe4, 3'h1, 8'h00); chk(source_mask_bits, 8'hf4);
        repeat (20) @(negedge clk);
        chk(n_acc, 8'h1);
        cmd(0, 0, 0, 1);
        wait_acc(16'h0008);
        cmd(0, 0, 1, 0);
        wait_acc(16'h000c);
        acc(0, 0, 16'hffe0, 3'h0, 8'h00); chk(sfr_rdata, 8'h00);
        // Pin 1 in output mode: a falling drive level counts as its edge
        @(negedge clk);
        pin_out_mode = 2'h2;
        @(negedge clk);
        pin_out_level = 2'h2;
        repeat (3) @(negedge clk);
        pin_out_level = 2'h0;
        repeat (4) @(negedge clk);
        acc(0, 0, 16'hffe0, 3'h0, 8'h00); chk(sfr_rdata, 8'h04);
        acc(0, 0, 16'hff00, 3'h0, 8'h00); chk(sfr_rdata, 8'h00);
        chk(request_flag_bits, 8'h04);
        chk(n_acc, 8'h3);
        results();
    end
endmodule
